/* sim/soi_contactor_model.sv */
// Contactor pair with feedback contacts on the machine side
`timescale 1ns/100ps
module soi_contactor_model #(
    parameter int DELAY = 3
) (
    // Clock
    input wire logic mclk,
    // Safety outputs and scenario controls
    input wire logic out1,
    input wire logic out2,
    input wire logic wired,
    input wire logic [1:0] fault,
    // Feedback contacts
    output logic fb
);
    // ==========================================
    // Contactors pull in a few cycles after both outputs
    logic [DELAY-1:0] pull = '0;
    always_ff @(posedge mclk) begin
        pull <= {pull[DELAY-2:0], out1 & out2};
    end
    // Unwired input rests low; 1 = welded, 2 = broken contact
    assign fb = !wired ? 1'h0 :
        (fault == 2'h1) ? 1'h1 : (fault == 2'h2) ? 1'h0 : ~pull[DELAY-1];
endmodule : soi_contactor_model

/* sim/soi_safety_output_interlock_tb_top.sv */
// Self-checking bench for the safety output interlock
`timescale 1ns/100ps
module soi_safety_output_interlock_tb_top;
    // ==========================================
    // Signals and instances
    localparam int EW = 20;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic fc = 1'h1, c1 = 1'h1, c2 = 1'h1, btn = 1'h0, sti = 1'h1, axs = 1'h0, fb;
    logic o1, o2, rro, aux, str, tch, byp, eto1, eto2, wired = 1'h0;
    logic [1:0] fault = 2'h0;
    int mismatches = 0, comparisons = 0, cyc = 0;
    always #4 mclk = ~mclk;
    soi_safety_output_interlock #(.EDM_WAIT_CYC(EW), .BLINK_HALF_CYC(8)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .field_clear(fc), .estop_ch1(c1), .estop_ch2(c2), .reset_button(btn),
        .contactor_feedback_monitor(fb), .sender_test_in(sti), .aux_source(axs),
        .safety_switch_output1(o1), .safety_switch_output2(o2), .reset_required_out(rro),
        .auxiliary_signal_output(aux), .estop_test_out1(eto1), .estop_test_out2(eto2),
        .sender_test_run(str), .teach_pulse(tch), .bypass_active(byp));
    soi_contactor_model i_model (.mclk(mclk), .out1(o1), .out2(o2), .wired(wired),
        .fault(fault), .fb(fb));
    // ==========================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic outs(input logic [1:0] e);
        chk({30'h0, o1, o2}, {30'h0, e});
    endtask : outs
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'h1;
        do tick(1); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        tick(1);
    endtask : apb
    task automatic err_is(input logic [7:0] e);
        apb(1'h0, soi_pkg::OFF_STATUS, 32'h0);
        chk({24'h0, rd[15:8]}, {24'h0, e});
    endtask : err_is
    task automatic press;
        btn <= 1'h1;
        tick(1);
        btn <= 1'h0;
        tick(1);
    endtask : press
    task automatic restart(input logic [7:0] cfg);
        wired <= 1'h0;
        rst_n <= 1'h0;
        tick(2);
        rst_n <= 1'h1;
        tick(1);
        apb(1'h1, soi_pkg::OFF_CONFIG, {24'h0, cfg});
    endtask : restart
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // ==========================================
    // Scenarios
    task automatic t_defaults;
        int n;
        logic p;
        n = 0;
        apb(1'h0, soi_pkg::OFF_CONFIG, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 8'h0C, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'h1, soi_pkg::OFF_STATUS, 32'hFF);
        apb(1'h0, soi_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h2);
        p = rro;
        repeat (32) begin
            tick(1);
            if (rro !== p) n++;
            p = rro;
        end
        chk(32'(n), 32'h4);
        outs(2'h0);
    endtask : t_defaults
    task automatic t_restart;
        restart(8'h00);
        fc <= 1'h0;
        press;
        outs(2'h0);
        fc <= 1'h1;
        press;
        outs(2'h3);
        fc <= 1'h0;
        tick(2);
        outs(2'h0);
        fc <= 1'h1;
        tick(4);
        outs(2'h0);
        restart(8'h01);
        tick(3);
        outs(2'h3);
    endtask : t_restart
    task automatic t_edm;
        restart(8'h02);
        wired <= 1'h1;
        press;
        tick(EW + 8);
        outs(2'h3);
        fault <= 2'h1;
        restart(8'h02);
        wired <= 1'h1;
        press;
        outs(2'h3);
        tick(EW + 4);
        outs(2'h0);
        err_is(soi_pkg::ERR_EDM_TIMEOUT);
        fault <= 2'h2;
        restart(8'h02);
        wired <= 1'h1;
        press;
        outs(2'h0);
        fault <= 2'h0;
    endtask : t_edm
    task automatic t_unmon;
        restart(8'h00);
        wired <= 1'h1;
        tick(3);
        err_is(soi_pkg::ERR_EDM_CONFIG);
        chk({31'h0, rd[soi_pkg::STS_LOCK_BIT]}, 32'h1);
        press;
        outs(2'h0);
        wired <= 1'h0;
        apb(1'h1, soi_pkg::OFF_COMMAND, 32'h1);
        err_is(soi_pkg::ERR_NONE);
    endtask : t_unmon
    task automatic t_estop;
        restart(8'h00);
        press;
        c1 <= 1'h0;
        tick(3);
        outs(2'h3);
        c1 <= 1'h1;
        apb(1'h1, soi_pkg::OFF_CONFIG, 32'h04);
        c1 <= 1'h0;
        c2 <= 1'h0;
        tick(2);
        outs(2'h0);
        chk({30'h0, eto1, eto2}, 32'h3);
        err_is(soi_pkg::ERR_NONE);
        c1 <= 1'h1;
        c2 <= 1'h1;
        press;
        outs(2'h3);
        c2 <= 1'h0;
        tick(2);
        outs(2'h0);
        err_is(soi_pkg::ERR_CHANNEL);
        restart(8'h14);
        press;
        outs(2'h3);
        c2 <= 1'h1;
        restart(8'h0C);
        tick(2);
        chk({31'h0, byp}, 32'h0);
        apb(1'h1, soi_pkg::OFF_CONFIG, 32'h08);
        tick(2);
        chk({31'h0, byp}, 32'h1);
    endtask : t_estop
    task automatic t_misc;
        int n;
        n = 0;
        restart(8'h00);
        axs <= 1'h1;
        sti <= 1'h0;
        tick(3);
        chk({30'h0, aux, str}, 32'h0);
        chk({30'h0, eto1, eto2}, 32'h0);
        apb(1'h1, soi_pkg::OFF_CONFIG, 32'hE0);
        tick(2);
        chk({30'h0, aux, str}, 32'h3);
        sti <= 1'h1;
        tick(3);
        chk({31'h0, str}, 32'h0);
        btn <= 1'h1;
        repeat (4) begin
            tick(1);
            btn <= 1'h0;
            if (tch === 1'h1) n++;
        end
        chk(32'(n), 32'h1);
    endtask : t_misc
    // ==========================================
    // Main sequence and timeout
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            complete_run;
        end
    end
    initial begin
        tick(16);
        rst_n <= 1'h1;
        tick(1);
        t_defaults;
        t_restart;
        t_edm;
        t_unmon;
        t_estop;
        t_misc;
        complete_run;
    end
endmodule : soi_safety_output_interlock_tb_top

/* src/soi_pkg.sv */
// Constants, types and register layout of the safety output interlock
package soi_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_COMMAND = 8'h08;
    localparam int CMD_CLEAR_BIT = 0;
    localparam int STS_ON_BIT = 0;
    localparam int STS_REQ_BIT = 1;
    localparam int STS_BLOCK_BIT = 2;
    localparam int STS_LOCK_BIT = 3;
    localparam int STS_BYPASS_BIT = 4;
    localparam int STS_ERR_LSB = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ==========================================
    // Error codes
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_EDM_CONFIG = 8'h22;
    localparam logic [7:0] ERR_CHANNEL = 8'h2C;
    localparam logic [7:0] ERR_EDM_TIMEOUT = 8'h30;
    // ==========================================
    // Timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned EDM_WAIT_MS = 300;
    localparam int unsigned BLINK_HZ = 1;
    localparam int unsigned EDM_WAIT_CYC = CLK_HZ / 1000 * EDM_WAIT_MS;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
    localparam int CNT_W = 26;
    // ==========================================
    // Types
    typedef enum logic [1:0] {ST_WAIT_RESET, ST_EDM_CHECK, ST_RUN, ST_LOCKOUT} soi_state_e;
    typedef struct packed {
        logic teach_single;
        logic sender_test_en;
        logic aux_en;
        logic complement;
        logic bypass_en;
        logic estop_en;
        logic edm_en;
        logic interlock_off;
    } soi_cfg_s;
endpackage : soi_pkg

/* src/soi_safety_output_interlock.sv */
// Safety output interlock with contactor monitoring and APB registers
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
module soi_safety_output_interlock #(
    parameter int unsigned EDM_WAIT_CYC = soi_pkg::EDM_WAIT_CYC,
    parameter int unsigned BLINK_HALF_CYC = soi_pkg::BLINK_HALF_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Field and operator inputs
    input wire logic field_clear,
    input wire logic estop_ch1,
    input wire logic estop_ch2,
    input wire logic reset_button,
    input wire logic contactor_feedback_monitor,
    input wire logic sender_test_in,
    input wire logic aux_source,
    // Machine side outputs
    output logic safety_switch_output1,
    output logic safety_switch_output2,
    output logic reset_required_out,
    output logic auxiliary_signal_output,
    output logic estop_test_out1,
    output logic estop_test_out2,
    output logic sender_test_run,
    output logic teach_pulse,
    output logic bypass_active
);
    // ==========================================
    // Channel decoding
    function automatic logic chan_closed(input logic c1, input logic c2, input logic comp);
        chan_closed = c1 & (comp ? ~c2 : c2);
    endfunction : chan_closed

    soi_pkg::soi_cfg_s cfg;
    soi_pkg::soi_state_e state;
    soi_pkg::soi_state_e next_state;
    logic [7:0] err_code;
    logic [7:0] next_err;
    logic [soi_pkg::CNT_W-1:0] edm_cnt;
    logic [soi_pkg::CNT_W-1:0] blink_cnt;
    logic reset_prev;
    logic [31:0] status_word;

    wire bypass_sel = cfg.bypass_en & ~cfg.estop_en;
    wire chan_used = cfg.estop_en | bypass_sel;
    wire chan_equal = estop_ch1 == estop_ch2;
    wire ch_mismatch = chan_used & (cfg.complement ? chan_equal : ~chan_equal);
    wire estop_open = cfg.estop_en & ~chan_closed(estop_ch1, estop_ch2, cfg.complement);
    wire bypass_req = bypass_sel & chan_closed(estop_ch1, estop_ch2, cfg.complement);
    wire release_ok = (field_clear | bypass_req) & ~estop_open;
    wire edm_cfg_fault = ~cfg.edm_en & contactor_feedback_monitor;
    wire edm_block = cfg.edm_en & ~contactor_feedback_monitor;
    wire press = reset_button & ~reset_prev;
    wire accept = press & release_ok & ~edm_block;
    wire auto_ok = release_ok & ~edm_block;
    wire start = cfg.interlock_off ? auto_ok : accept;
    wire lock_cause = edm_cfg_fault | ch_mismatch;
    wire edm_done = edm_cnt == soi_pkg::CNT_W'(EDM_WAIT_CYC - 1);
    wire blink_done = blink_cnt == soi_pkg::CNT_W'(BLINK_HALF_CYC - 1);
    wire waiting = state == soi_pkg::ST_WAIT_RESET;
    wire next_on = next_state == soi_pkg::ST_EDM_CHECK || next_state == soi_pkg::ST_RUN;

    // ==========================================
    // APB decode
    wire sel_cfg = paddr == soi_pkg::OFF_CONFIG;
    wire sel_sts = paddr == soi_pkg::OFF_STATUS;
    wire sel_cmd = paddr == soi_pkg::OFF_COMMAND;
    wire addr_hit = sel_cfg | sel_sts | sel_cmd;
    wire next_pready = psel & penable & ~pready;
    wire done_xfer = psel & penable & pready;
    wire wr_cfg = done_xfer & pwrite & sel_cfg;
    wire clear_cmd = done_xfer & pwrite & sel_cmd & pwdata[soi_pkg::CMD_CLEAR_BIT];
    wire [31:0] rd_mux = sel_cfg ? {24'h000000, cfg} : (sel_sts ? status_word : 32'h00000000);

    always_comb begin
        status_word = 32'h00000000;
        status_word[soi_pkg::STS_ON_BIT] = safety_switch_output1;
        status_word[soi_pkg::STS_REQ_BIT] = waiting;
        status_word[soi_pkg::STS_BLOCK_BIT] = edm_block;
        status_word[soi_pkg::STS_LOCK_BIT] = state == soi_pkg::ST_LOCKOUT;
        status_word[soi_pkg::STS_BYPASS_BIT] = bypass_req;
        status_word[soi_pkg::STS_ERR_LSB +: 8] = err_code;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pready & ~addr_hit;
            prdata <= (next_pready & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg <= soi_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg <= pwdata[7:0];
        end
    end

    // ==========================================
    // Interlock sequencer
    always_comb begin
        next_state = state;
        next_err = err_code;
        if (clear_cmd) begin
            next_err = soi_pkg::ERR_NONE;
        end
        unique case (state)
            soi_pkg::ST_LOCKOUT: begin
                if (clear_cmd) begin
                    next_state = soi_pkg::ST_WAIT_RESET;
                end
            end
            soi_pkg::ST_WAIT_RESET: begin
                if (start) begin
                    next_state = cfg.edm_en ? soi_pkg::ST_EDM_CHECK : soi_pkg::ST_RUN;
                end
            end
            soi_pkg::ST_EDM_CHECK: begin
                if (!release_ok) begin
                    next_state = soi_pkg::ST_WAIT_RESET;
                end else if (!contactor_feedback_monitor) begin
                    next_state = soi_pkg::ST_RUN;
                end else if (edm_done) begin
                    next_state = soi_pkg::ST_WAIT_RESET;
                    next_err = soi_pkg::ERR_EDM_TIMEOUT;
                end
            end
            soi_pkg::ST_RUN: begin
                if (!release_ok) begin
                    next_state = soi_pkg::ST_WAIT_RESET;
                end
            end
        endcase
        if (lock_cause) begin
            next_state = soi_pkg::ST_LOCKOUT;
            next_err = edm_cfg_fault ? soi_pkg::ERR_EDM_CONFIG : soi_pkg::ERR_CHANNEL;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= soi_pkg::ST_WAIT_RESET;
            err_code <= soi_pkg::ERR_NONE;
            reset_prev <= 1'b0;
        end else begin
            state <= next_state;
            err_code <= next_err;
            reset_prev <= reset_button;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || state != soi_pkg::ST_EDM_CHECK) begin
            edm_cnt <= '0;
        end else begin
            edm_cnt <= edm_cnt + 1'b1;
        end
    end

    // ==========================================
    // Output drivers
    always_ff @(posedge mclk) begin
        if (!rst_n || !waiting || cfg.interlock_off || blink_done) begin
            blink_cnt <= '0;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            safety_switch_output1 <= 1'b0;
            safety_switch_output2 <= 1'b0;
            reset_required_out <= 1'b0;
            auxiliary_signal_output <= 1'b0;
            estop_test_out1 <= 1'b0;
            estop_test_out2 <= 1'b0;
            sender_test_run <= 1'b0;
            teach_pulse <= 1'b0;
            bypass_active <= 1'b0;
        end else begin
            safety_switch_output1 <= next_on;
            safety_switch_output2 <= next_on;
            if (!waiting || cfg.interlock_off) begin
                reset_required_out <= 1'b0;
            end else if (blink_done) begin
                reset_required_out <= ~reset_required_out;
            end
            auxiliary_signal_output <= cfg.aux_en & aux_source;
            estop_test_out1 <= chan_used;
            estop_test_out2 <= chan_used;
            sender_test_run <= cfg.sender_test_en & ~sender_test_in;
            teach_pulse <= cfg.teach_single & press;
            bypass_active <= bypass_req;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_edm_timeout_off: assert property (
        state == soi_pkg::ST_EDM_CHECK && edm_done && release_ok && contactor_feedback_monitor
        && !lock_cause |=> !safety_switch_output1 && !safety_switch_output2
        && err_code == soi_pkg::ERR_EDM_TIMEOUT) else $error("edm timeout kept outputs on");
    a_edm_block_start: assert property (
        waiting && edm_block |=> !safety_switch_output1) else $error("restart despite edm");
    a_edm_cfg_lock: assert property (
        edm_cfg_fault |=> state == soi_pkg::ST_LOCKOUT && err_code == soi_pkg::ERR_EDM_CONFIG)
        else $error("no lockout on unmonitored feedback");
    a_interlock_hold: assert property (
        waiting && !cfg.interlock_off && !press |=> !safety_switch_output2)
        else $error("restart without reset press");
    a_teach_pulse: assert property (
        press && cfg.teach_single |=> teach_pulse ##1 !teach_pulse) else $error("teach pulse");
    a_cfg_defaults: assert property (
        $rose(rst_n) |-> !cfg.interlock_off && !cfg.estop_en && !cfg.aux_en)
        else $error("config defaults wrong");
    a_blink_only_wait: assert property (
        !waiting |=> !reset_required_out) else $error("reset request blinks while not waiting");
    a_estop_drop: assert property (
        state == soi_pkg::ST_RUN && estop_open |=> !safety_switch_output1 && !safety_switch_output2)
        else $error("estop did not drop outputs");
    a_channel_lock: assert property (
        ch_mismatch |=> state == soi_pkg::ST_LOCKOUT ##1 !safety_switch_output1)
        else $error("channel mismatch not locked");
    a_bypass_excl: assert property (
        cfg.estop_en |=> !bypass_active) else $error("bypass with estop enabled");
    a_aux_gate: assert property (
        !cfg.aux_en [*2] |-> !auxiliary_signal_output) else $error("aux output while disabled");
    a_sender_test: assert property (
        cfg.sender_test_en && !sender_test_in |=> sender_test_run) else $error("sender test");
    a_sender_ignore: assert property (
        !cfg.sender_test_en || sender_test_in |=> !sender_test_run) else $error("test not ignored");
    a_outputs_pair: assert property (
        safety_switch_output1 == safety_switch_output2) else $error("switch outputs disagree");
    a_reset_gate: assert property (
        waiting && !cfg.interlock_off && !release_ok |=> !safety_switch_output1)
        else $error("reset accepted with field or stop open");

    c_run_reached: cover property (state == soi_pkg::ST_EDM_CHECK ##1 state == soi_pkg::ST_RUN);
    c_lockout: cover property (state == soi_pkg::ST_LOCKOUT);
    c_edm_timeout: cover property (err_code == soi_pkg::ERR_EDM_TIMEOUT);
    c_teach: cover property (teach_pulse);
endmodule : soi_safety_output_interlock
